// ===== hw/kms_pkg.sv
// Purpose: constants shared by the keyboard matrix scan block
// Assumes: APB word registers, one aligned word each
// Notes:   byte offsets relative to the block base
package kms_pkg;
    localparam int           COL_W          = 8;
    localparam int           ROW_N          = 18;
    localparam int           SEL_W          = 5;
    localparam logic [31:0]  BLOCK_BASE     = 32'h0000_9c00;
    localparam int           ADDR_W         = 8;
    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [7:0]   OFF_RSVD       = 8'h00;
    localparam logic [7:0]   OFF_ROW_SEL    = 8'h04;
    localparam logic [7:0]   OFF_COL_IN     = 8'h08;
    localparam logic [7:0]   OFF_COL_STS    = 8'h0c;
    localparam logic [7:0]   OFF_COL_IEN    = 8'h10;
    localparam logic [7:0]   OFF_EXT_CTL    = 8'h14;
    // ------------------------------------------------------------
    // row select and external control fields
    // ------------------------------------------------------------
    localparam int           POS_PICK_LO    = 0;
    localparam int           POS_ALL_ON     = 5;
    localparam int           POS_SCAN_DIS   = 6;
    localparam int           POS_INVERT     = 7;
    localparam int           POS_PREDRIVE   = 0;
    localparam logic [4:0]   PICK_MAX       = 5'h11;
    localparam logic [4:0]   RST_PICK       = 5'h00;
    localparam logic         RST_SCAN_DIS   = 1'b1;
    // ------------------------------------------------------------
    // timing and power state
    // ------------------------------------------------------------
    localparam int           CLK_MHZ        = 25;
    localparam int           PREDRIVE_NS    = 80;
    localparam int           PREDRIVE_CYC   = (PREDRIVE_NS * CLK_MHZ + 999) / 1000;
    localparam logic [3:0]   PREDRIVE_LOAD  = 4'(PREDRIVE_CYC);
    typedef enum logic {KMS_LOWPWR, KMS_ACTIVE} kms_pwr_t;
endpackage

// ===== hw/kms_scan.sv
// Purpose: keyboard matrix scan block, APB register slave
// Assumes: column inputs synchronous to nothing; synchronised here
// Notes:   clockless edge capture is modelled on the system clock
//
// Decided for this implementation: the APB slave port and the register addresses.
`timescale 1ns/10ps
`default_nettype none
module kms_scan
    import kms_pkg::*;
#(
    parameter int COLS = kms_pkg::COL_W,
    parameter int ROWS = kms_pkg::ROW_N
) (
    input  wire logic                        clock,
    input  wire logic                        rst,
    input  wire logic                        psel,
    input  wire logic                        penable,
    input  wire logic                        pwrite,
    input  wire logic [kms_pkg::ADDR_W-1:0]  paddr,
    input  wire logic [31:0]                 pwdata,
    output logic      [31:0]                 prdata,
    output logic                             pready,
    output logic                             pslverr,
    input  wire logic [COLS-1:0]             columnIn,
    output logic      [ROWS-1:0]             rowOut,
    output logic      [ROWS-1:0]             rowOutEn,
    input  wire logic                        busClockStopped,
    output logic                             scanIrq,
    output logic                             scanWakeReq,
    output logic                             clockReqStatus2,
    output logic                             sleepHold
);
    import kms_pkg::*;

    // ------------------------------------------------------------
    // decode helpers
    // ------------------------------------------------------------
    function automatic logic [ROWS-1:0] rowDecode(input logic [SEL_W-1:0] pick);
        logic [ROWS-1:0] v;
        v = '0;
        for (int i = 0; i < ROWS; i++) begin
            if (pick == SEL_W'(i)) begin
                v[i] = 1'b1;
            end
        end
        return v;
    endfunction

    // ------------------------------------------------------------
    // apb slave
    // ------------------------------------------------------------
    logic [SEL_W-1:0] rowPick_q, rowPick_d;
    logic             allRowsOn_q, allRowsOn_d;
    logic             scanDisable_q, scanDisable_d;
    logic             invert_q, invert_d;
    logic             predriveEn_q, predriveEn_d;
    logic [COLS-1:0]  colStatus_q, colStatus_d;
    logic [COLS-1:0]  colEnable_q, colEnable_d;
    logic [31:0]      prdata_q, prdata_d;
    logic             pready_q, pready_d;
    logic             pslverr_q, pslverr_d;
    logic [COLS-1:0]  colMeta_q, colSync_q, colPrev_q;
    logic             wrDone, selWrite;
    logic [COLS-1:0]  colFall, stsClear;
    logic             mapped;

    assign wrDone   = psel && penable && pready_q && pwrite;
    assign selWrite = wrDone && paddr == OFF_ROW_SEL;
    // only the second and third stages feed the edge logic
    assign colFall  = colPrev_q & ~colSync_q;

    always_comb begin
        mapped = paddr == OFF_RSVD || paddr == OFF_ROW_SEL || paddr == OFF_COL_IN
              || paddr == OFF_COL_STS || paddr == OFF_COL_IEN || paddr == OFF_EXT_CTL;
        pready_d      = psel && penable && !pready_q;
        pslverr_d     = pready_d && !mapped;
        prdata_d      = prdata_q;
        rowPick_d     = rowPick_q;
        allRowsOn_d   = allRowsOn_q;
        scanDisable_d = scanDisable_q;
        invert_d      = invert_q;
        predriveEn_d  = predriveEn_q;
        colEnable_d   = colEnable_q;
        stsClear      = '0;
        if (pready_d && !pwrite) begin
            case (paddr)
                OFF_ROW_SEL: begin
                    prdata_d = {24'h00_0000, invert_q, scanDisable_q, allRowsOn_q, rowPick_q};
                end
                OFF_COL_IN:  prdata_d = 32'(colSync_q);
                OFF_COL_STS: prdata_d = 32'(colStatus_q);
                OFF_COL_IEN: prdata_d = 32'(colEnable_q);
                OFF_EXT_CTL: prdata_d = 32'(predriveEn_q);
                default:     prdata_d = 32'h0000_0000;
            endcase
        end
        if (wrDone) begin
            case (paddr)
                OFF_ROW_SEL: begin
                    rowPick_d     = pwdata[POS_PICK_LO +: SEL_W];
                    allRowsOn_d   = pwdata[POS_ALL_ON];
                    scanDisable_d = pwdata[POS_SCAN_DIS];
                    invert_d      = pwdata[POS_INVERT];
                end
                OFF_COL_STS: stsClear = pwdata[COLS-1:0];
                OFF_COL_IEN: colEnable_d = pwdata[COLS-1:0];
                OFF_EXT_CTL: predriveEn_d = pwdata[POS_PREDRIVE];
                default: ;
            endcase
        end
        // set beats clear when an edge lands on the clearing write
        colStatus_d = (colStatus_q & ~stsClear) | colFall;
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            rowPick_q     <= RST_PICK;
            allRowsOn_q   <= 1'b0;
            scanDisable_q <= RST_SCAN_DIS;
            invert_q      <= 1'b0;
            predriveEn_q  <= 1'b0;
            colStatus_q   <= '0;
            colEnable_q   <= '0;
            prdata_q      <= 32'h0000_0000;
            pready_q      <= 1'b0;
            pslverr_q     <= 1'b0;
            colMeta_q     <= '1;
            colSync_q     <= '1;
            colPrev_q     <= '1;
        end else begin
            rowPick_q     <= rowPick_d;
            allRowsOn_q   <= allRowsOn_d;
            scanDisable_q <= scanDisable_d;
            invert_q      <= invert_d;
            predriveEn_q  <= predriveEn_d;
            colStatus_q   <= colStatus_d;
            colEnable_q   <= colEnable_d;
            prdata_q      <= prdata_d;
            pready_q      <= pready_d;
            pslverr_q     <= pslverr_d;
            colMeta_q     <= columnIn;
            colSync_q     <= colMeta_q;
            colPrev_q     <= colSync_q;
        end
    end

    assign prdata  = prdata_q;
    assign pready  = pready_q;
    assign pslverr = pslverr_q;

    // ------------------------------------------------------------
    // row drive and pre-drive
    // ------------------------------------------------------------
    logic [ROWS-1:0] rowOut_q, rowOut_d, rowOutEn_q, rowOutEn_d;
    logic [ROWS-1:0] active, activePrev_q, pdMask_q, pdMask_d;
    logic [3:0]      pdCnt_q, pdCnt_d;
    logic            bigPick, level;

    always_comb begin
        bigPick = !allRowsOn_q && rowPick_q > PICK_MAX;
        // above the last row, with all-rows-on clear, every row is on with the level sense flipped
        level   = bigPick ? !invert_q : invert_q;
        if (scanDisable_q) begin
            active = '0;
        end else if (allRowsOn_q || bigPick) begin
            active = '1;
        end else begin
            active = rowDecode(rowPick_q);
        end
        pdMask_d = pdMask_q;
        pdCnt_d  = pdCnt_q;
        if (scanDisable_q || !predriveEn_q) begin
            pdMask_d = '0;
            pdCnt_d  = '0;
        end else if ((activePrev_q & ~active) != '0) begin
            pdMask_d = (pdMask_q | (activePrev_q & ~active)) & ~active;
            pdCnt_d  = PREDRIVE_LOAD;
        end else if (pdCnt_q != 4'h0) begin
            pdCnt_d  = pdCnt_q - 4'h1;
            if (pdCnt_q == 4'h1) begin
                pdMask_d = '0;
            end
        end
        for (int i = 0; i < ROWS; i++) begin
            rowOut_d[i]   = active[i] ? level : 1'b1;
            rowOutEn_d[i] = active[i] || pdMask_d[i];
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            rowOut_q     <= '1;
            rowOutEn_q   <= '0;
            activePrev_q <= '0;
            pdMask_q     <= '0;
            pdCnt_q      <= 4'h0;
        end else begin
            rowOut_q     <= rowOut_d;
            rowOutEn_q   <= rowOutEn_d;
            activePrev_q <= active;
            pdMask_q     <= pdMask_d;
            pdCnt_q      <= pdCnt_d;
        end
    end

    assign rowOut   = rowOut_q;
    assign rowOutEn = rowOutEn_q;

    // ------------------------------------------------------------
    // interrupts, wake and power state
    // ------------------------------------------------------------
    logic     scanIrq_q, scanIrq_d, blocked_q, blocked_d;
    logic     wake_q, wake_d, clkReq_q, clkReq_d;
    kms_pwr_t pwr_q, pwr_d;
    logic     sleepHold_q, sleepHold_d;
    logic     anyTerm;

    always_comb begin
        anyTerm   = |(colStatus_q & colEnable_q);
        blocked_d = blocked_q;
        if (scanIrq_q && !anyTerm) begin
            blocked_d = 1'b1;
        end
        if (&colSync_q || selWrite) begin
            blocked_d = 1'b0;
        end
        // held low while the bus clock is off, fires on resume
        scanIrq_d = anyTerm && !blocked_d && !busClockStopped;
        wake_d    = wake_q;
        clkReq_d  = clkReq_q;
        if (!busClockStopped) begin
            wake_d   = 1'b0;
            clkReq_d = 1'b0;
        end else if ((colFall & colEnable_q) != '0) begin
            wake_d   = 1'b1;
            clkReq_d = 1'b1;
        end
        case (pwr_q)
            KMS_LOWPWR: pwr_d = scanDisable_q ? KMS_LOWPWR : KMS_ACTIVE;
            KMS_ACTIVE: pwr_d = scanDisable_q ? KMS_LOWPWR : KMS_ACTIVE;
            default:    pwr_d = KMS_LOWPWR;
        endcase
        sleepHold_d = pwr_d == KMS_ACTIVE;
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            scanIrq_q   <= 1'b0;
            blocked_q   <= 1'b0;
            wake_q      <= 1'b0;
            clkReq_q    <= 1'b0;
            pwr_q       <= KMS_LOWPWR;
            sleepHold_q <= 1'b0;
        end else begin
            scanIrq_q   <= scanIrq_d;
            blocked_q   <= blocked_d;
            wake_q      <= wake_d;
            clkReq_q    <= clkReq_d;
            pwr_q       <= pwr_d;
            sleepHold_q <= sleepHold_d;
        end
    end

    assign scanIrq         = scanIrq_q;
    assign scanWakeReq     = wake_q;
    assign clockReqStatus2 = clkReq_q;
    assign sleepHold       = sleepHold_q;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    property p_statusSet;
        @(posedge clock) disable iff (rst) (colFall != '0) |=> ((colStatus_q & $past(colFall)) == $past(colFall));
    endproperty
    a_statusSet: assert property (p_statusSet) else $error("column fall did not set status");

    property p_w1c;
        @(posedge clock) disable iff (rst) (wrDone && paddr == OFF_COL_STS && colFall == '0)
            |=> ((colStatus_q & $past(pwdata[COLS-1:0])) == '0);
    endproperty
    a_w1c: assert property (p_w1c) else $error("write one did not clear status");

    property p_irqOr;
        @(posedge clock) disable iff (rst) scanIrq_q |-> $past(anyTerm);
    endproperty
    a_irqOr: assert property (p_irqOr) else $error("irq without enabled status");

    property p_disableRows;
        @(posedge clock) disable iff (rst) scanDisable_q |=> rowOutEn_q == '0;
    endproperty
    a_disableRows: assert property (p_disableRows) else $error("rows driven while disabled");

    property p_wakeSet;
        @(posedge clock) disable iff (rst) (busClockStopped && (colFall & colEnable_q) != '0)
            |=> scanWakeReq && clockReqStatus2;
    endproperty
    a_wakeSet: assert property (p_wakeSet) else $error("no wake on sleep edge");

    property p_wakeHold;
        @(posedge clock) disable iff (rst) (scanWakeReq && busClockStopped) |=> scanWakeReq;
    endproperty
    a_wakeHold: assert property (p_wakeHold) else $error("wake dropped while clock stopped");

    property p_apbAnswer;
        @(posedge clock) disable iff (rst) (psel && penable && !pready_q) |=> pready_q;
    endproperty
    a_apbAnswer: assert property (p_apbAnswer) else $error("apb access not answered");

    property p_resetDisable;
        @(posedge clock) rst |=> scanDisable_q && !sleepHold_q;
    endproperty
    a_resetDisable: assert property (p_resetDisable) else $error("reset left scan enabled");

    property p_sleepHold;
        @(posedge clock) disable iff (rst) !scanDisable_q ##1 !scanDisable_q |-> sleepHold_q;
    endproperty
    a_sleepHold: assert property (p_sleepHold) else $error("scanning without sleep hold");

    c_irq:      cover property (@(posedge clock) disable iff (rst) $rose(scanIrq_q));
    c_wake:     cover property (@(posedge clock) disable iff (rst) $rose(scanWakeReq));
    c_predrive: cover property (@(posedge clock) disable iff (rst) pdMask_q != '0);
endmodule
`default_nettype wire

// ===== verification/kms_key_matrix.sv
// Purpose: passive key matrix with pull-ups on rows and columns
// Assumes: a pressed key joins its row to its column
// Notes:   an undriven row rests at its pull-up and pulls nothing
`timescale 1ns/10ps
`default_nettype none
module kms_key_matrix (
    input  wire logic [kms_pkg::ROW_N-1:0]               rowOut,
    input  wire logic [kms_pkg::ROW_N-1:0]               rowOutEn,
    input  wire logic [kms_pkg::ROW_N*kms_pkg::COL_W-1:0] keys,
    output logic      [kms_pkg::COL_W-1:0]               columnIn
);
    import kms_pkg::*;
    always_comb begin
        columnIn = '1; // column pull-ups
        for (int r = 0; r < ROW_N; r++) begin
            for (int c = 0; c < COL_W; c++) begin
                // only a row driven low reaches a column
                if (keys[r*COL_W+c] && rowOutEn[r] && !rowOut[r]) begin
                    columnIn[c] = 1'b0;
                end
            end
        end
    end
endmodule
`default_nettype wire

// ===== verification/tb.sv
// Purpose: self-checking bench for the matrix scan block
// Assumes: APB slave answers in its own time; key matrix model on rows
// Notes:   pad push-pull or open-drain choice lies outside the block
`timescale 1ns/10ps
`default_nettype none
module tb;
    import kms_pkg::*;
    typedef struct packed {logic [7:0] sel; logic [17:0] en; logic [17:0] lvl; logic hold;} kms_row_t;
    logic clock, rst, psel, penable, pwrite, busClockStopped;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rdData;
    logic pready, pslverr, rdErr, scanIrq, scanWakeReq, clockReqStatus2, sleepHold;
    logic [COL_W-1:0] columnIn;
    logic [ROW_N-1:0] rowOut, rowOutEn;
    logic [ROW_N*COL_W-1:0] keys;
    int error_cnt, num_checks, n;
    kms_row_t rows [8] = '{
        '{8'h00, 18'h00001, 18'h3fffe, 1'b1}, '{8'h11, 18'h20000, 18'h1ffff, 1'b1},
        '{8'h20, 18'h3ffff, 18'h00000, 1'b1}, '{8'h83, 18'h00008, 18'h3ffff, 1'b1},
        '{8'h12, 18'h3ffff, 18'h3ffff, 1'b1}, '{8'h9f, 18'h3ffff, 18'h00000, 1'b1},
        '{8'h40, 18'h00000, 18'h3ffff, 1'b0}, '{8'h60, 18'h00000, 18'h3ffff, 1'b0}};
    kms_scan uut (.clock(clock), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .columnIn(columnIn), .rowOut(rowOut), .rowOutEn(rowOutEn),
        .busClockStopped(busClockStopped), .scanIrq(scanIrq), .scanWakeReq(scanWakeReq),
        .clockReqStatus2(clockReqStatus2), .sleepHold(sleepHold));
    kms_key_matrix matrix (.rowOut(rowOut), .rowOutEn(rowOutEn), .keys(keys),
        .columnIn(columnIn));
    always #20 clock = ~clock;
    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic print_verdict();
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic cmp(input string nm, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic tick(input int k);
        repeat (k) @(posedge clock);
    endtask
    // called just after a rising edge; one idle edge after release
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int t;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        t = 0;
        do begin
            @(posedge clock);
            t++;
        end while (pready !== 1'b1 && t < 20);
        if (pready !== 1'b1) begin
            error_cnt++;
            print_verdict();
        end
        rdData = prdata;
        rdErr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clock);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        cmp($sformatf("reg %h", a), exp, rdData);
    endtask
    task automatic flags(input logic irq, input logic wake);
        cmp("scanIrq", 32'(irq), 32'(scanIrq));
        cmp("scanWakeReq", 32'(wake), 32'(scanWakeReq));
        cmp("clockReqStatus2", 32'(wake), 32'(clockReqStatus2));
    endtask
    task automatic defaults();
        cmp("rowOut", 32'h3ffff, 32'(rowOut));
        cmp("rowOutEn", 32'h0, 32'(rowOutEn));
        cmp("sleepHold", 32'h0, 32'(sleepHold));
        flags(1'b0, 1'b0);
        rd(OFF_ROW_SEL, 32'h40);
        rd(OFF_COL_STS, 32'h0);
        rd(OFF_COL_IEN, 32'h0);
        rd(OFF_EXT_CTL, 32'h0);
    endtask
    // cycles a leaving row is driven high
    task automatic meas(input logic [7:0] sel, input int row);
        n = 0;
        wr(OFF_ROW_SEL, 32'(sel));
        for (int i = 0; i < 10; i++) begin
            @(posedge clock);
            if (rowOutEn[row] === 1'b1 && rowOut[row] === 1'b1) n++;
        end
    endtask
    // ------------------------------------------------------------
    // sequence
    // ------------------------------------------------------------
    initial begin
        clock = 0;
        rst = 1;
        psel = 0;
        penable = 0;
        pwrite = 0;
        paddr = 8'h00;
        pwdata = 32'h0;
        keys = '0;
        busClockStopped = 0;
        error_cnt = 0;
        num_checks = 0;
        tick(6);
        rst <= 1'b0;
        tick(1);
        defaults();
        rd(8'h18, 32'h0);
        cmp("pslverr", 32'h1, 32'(rdErr));
        rd(OFF_RSVD, 32'h0);
        cmp("pslverr", 32'h0, 32'(rdErr));
        for (int i = 0; i < 8; i++) begin
            wr(OFF_ROW_SEL, 32'(rows[i].sel));
            tick(6);
            cmp("rowOutEn", 32'(rows[i].en), 32'(rowOutEn));
            cmp("rowOut", 32'(rows[i].lvl), 32'(rowOut));
            cmp("sleepHold", 32'(rows[i].hold), 32'(sleepHold));
            rd(OFF_ROW_SEL, 32'(rows[i].sel));
        end
        wr(OFF_ROW_SEL, 32'h03);
        wr(OFF_COL_IEN, 32'h20);
        keys[3*COL_W+5] <= 1'b1;
        tick(8);
        rd(OFF_COL_IN, 32'hdf);
        rd(OFF_COL_STS, 32'h20);
        flags(1'b1, 1'b0);
        wr(OFF_COL_STS, 32'h0);
        rd(OFF_COL_STS, 32'h20);
        wr(OFF_COL_STS, 32'h20);
        tick(2);
        rd(OFF_COL_STS, 32'h0);
        flags(1'b0, 1'b0);
        wr(OFF_COL_IEN, 32'h60);
        keys[3*COL_W+6] <= 1'b1;
        tick(8);
        flags(1'b0, 1'b0);
        wr(OFF_ROW_SEL, 32'h03);
        tick(4);
        flags(1'b1, 1'b0);
        wr(OFF_COL_STS, 32'h60);
        keys <= '0;
        tick(8);
        busClockStopped <= 1'b1;
        keys[3*COL_W+5] <= 1'b1;
        tick(8);
        flags(1'b0, 1'b1);
        busClockStopped <= 1'b0;
        tick(6);
        flags(1'b1, 1'b0);
        rd(OFF_COL_STS, 32'h20);
        wr(OFF_COL_STS, 32'h20);
        keys <= '0;
        meas(8'h04, 3);
        cmp("no predrive", 32'h0, 32'(n));
        wr(OFF_ROW_SEL, 32'h43);
        wr(OFF_EXT_CTL, 32'h1);
        wr(OFF_ROW_SEL, 32'h03);
        meas(8'h04, 3);
        cmp("predrive", 32'(PREDRIVE_CYC), 32'(n));
        wr(OFF_ROW_SEL, 32'h44);
        wr(OFF_EXT_CTL, 32'h0);
        wr(OFF_ROW_SEL, 32'h04);
        meas(8'h05, 4);
        cmp("predrive off", 32'h0, 32'(n));
        rst <= 1'b1;
        tick(2);
        rst <= 1'b0;
        tick(1);
        defaults();
        print_verdict();
    end
endmodule
`default_nettype wire
